// ---- logic/lpc_pkg.sv ----
// package: register map, field layout, reset values, timing and bus carriers of the oscillator calibration block
package lpc_pkg;

    // register byte addresses
    localparam logic [31:0] TRIM_ADDR = 32'hFFFF042C;
    localparam logic [31:0] CTRL_ADDR = 32'hFFFF0440;
    localparam logic [31:0] STAT_ADDR = 32'hFFFF0444;
    localparam logic [31:0] REF_ADDR = 32'hFFFF0448;
    localparam logic [31:0] LP_ADDR = 32'hFFFF044C;
    localparam logic [31:0] INT_STAT_ADDR = 32'hFFFF0450;
    localparam logic [31:0] INT_MASK_ADDR = 32'hFFFF0454;

    // field widths and positions
    localparam int TRIM_W = 4;
    localparam int CTRL_W = 5;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_REF_BIT = 1;
    localparam int CTRL_CLR_LP_BIT = 2;
    localparam int CTRL_RST_BIT = 3;
    localparam int CTRL_SRC_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int INT_W = 2;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_TMO_BIT = 1;
    localparam int REF_W = 9;
    localparam int LP_W = 10;
    localparam int DIV_W = 2;
    localparam int TMR_W = 20;

    // reset values and fixed counts
    localparam logic [TRIM_W-1:0] TRIM_RST = 4'h8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    localparam logic [REF_W-1:0] REF_FULL = 9'h1FF;
    localparam logic [DIV_W-1:0] DIV_LAST = 2'h3;

    // timing: expected pass length per reference, watchdog at twice that
    localparam int unsigned PCLK_HZ = 20_000_000;
    localparam int unsigned PASS_INT_US = 4000;
    localparam int unsigned PASS_XTAL_US = 16000;
    localparam int unsigned TMO_FACTOR = 2;
    localparam int unsigned PASS_INT_TMO_CYC = PASS_INT_US * (PCLK_HZ / 1_000_000) * TMO_FACTOR;
    localparam int unsigned PASS_XTAL_TMO_CYC = PASS_XTAL_US * (PCLK_HZ / 1_000_000) * TMO_FACTOR;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } lpc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lpc_apb_rsp_t;

endpackage

// ---- logic/lpc_edge_cnt.sv ----
// edge counter clocked by pclk, counting rising edges of the sampled level of a slow oscillator, with optional divide-by-four
module lpc_edge_cnt
    import lpc_pkg::*;
#(
    parameter int unsigned WIDTH = 9
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // oscillator level and control
    input logic osc_lvl,
    input logic div4_en,
    input logic run,
    input logic clear,
    // count
    output logic [WIDTH-1:0] count
);

    typedef struct packed {
        logic prev;
        logic [DIV_W-1:0] pre;
        logic [WIDTH-1:0] cnt;
    } lpc_cnt_state_t;

    lpc_cnt_state_t s_q;
    lpc_cnt_state_t s_d;
    logic rise;
    logic step;

    always_comb begin
        s_d = s_q;
        s_d.prev = osc_lvl;
        rise = osc_lvl & ~s_q.prev;
        step = 1'b0;
        if (clear) begin
            s_d.cnt = '0;
            s_d.pre = '0;
        end else if (run && rise) begin
            if (div4_en) begin
                s_d.pre = s_q.pre + 2'h1;
                step = (s_q.pre == DIV_LAST);
            end else begin
                step = 1'b1;
            end
        end
        // saturate so a stuck reference cannot wrap the count
        if (step && (s_q.cnt != {WIDTH{1'b1}})) begin
            s_d.cnt = s_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // the count lives in the register clock domain, so software reads a settled value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;

endmodule

// ---- logic/lpc_calib.sv ----
// top of the low-power oscillator calibration block with its APB register slave
module lpc_calib
    import lpc_pkg::*;
#(
    parameter int unsigned INT_TMO_CYC = PASS_INT_TMO_CYC,
    parameter int unsigned XTAL_TMO_CYC = PASS_XTAL_TMO_CYC
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // register bus
    input lpc_apb_req_t apb_i,
    output lpc_apb_rsp_t apb_o,
    // oscillator levels, sampled on pclk
    input logic prec_osc,
    input logic xtal_osc,
    input logic lp_osc,
    // oscillator trim and interrupt
    output logic [TRIM_W-1:0] lp_trim,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [TRIM_W-1:0] trim;
        logic [CTRL_W-1:0] ctrl;
        logic busy;
        logic done;
        logic [TMR_W-1:0] timer;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } lpc_state_t;

    localparam logic [TMR_W-1:0] LIM_INT = TMR_W'(INT_TMO_CYC);
    localparam logic [TMR_W-1:0] LIM_XTAL = TMR_W'(XTAL_TMO_CYC);

    lpc_state_t s_q;
    lpc_state_t s_d;
    logic [REF_W-1:0] ref_cnt;
    logic [LP_W-1:0] lp_cnt;
    logic ref_full;
    logic ref_lvl;
    logic setup;
    logic access;
    logic hit;
    logic wr_ctrl;
    logic start;
    logic abort;
    logic run;
    logic ref_clr;
    logic lp_clr;
    logic [TMR_W-1:0] limit;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // counters

    // a source switch can look like one edge; counts taken across a switch are invalid
    assign ref_lvl = s_q.ctrl[CTRL_SRC_BIT] ? xtal_osc : prec_osc;
    assign ref_full = (ref_cnt == REF_FULL);

    lpc_edge_cnt #(.WIDTH(REF_W)) u_ref_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .osc_lvl(ref_lvl),
        .div4_en(1'b0),
        .run(run),
        .clear(ref_clr),
        .count(ref_cnt)
    );

    // crystal reference runs at a quarter rate, so the low-power side is divided to match
    lpc_edge_cnt #(.WIDTH(LP_W)) u_lp_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .osc_lvl(lp_osc),
        .div4_en(s_d.ctrl[CTRL_SRC_BIT]),
        .run(run),
        .clear(lp_clr),
        .count(lp_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode and read mux

    assign setup = apb_i.psel & ~apb_i.penable;
    assign access = apb_i.psel & apb_i.penable & s_q.pready;

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (apb_i.paddr)
            TRIM_ADDR: rdata[TRIM_W-1:0] = s_q.trim;
            CTRL_ADDR: rdata[CTRL_W-1:0] = s_q.ctrl;
            STAT_ADDR: begin
                rdata[STAT_BUSY_BIT] = s_q.busy;
                rdata[STAT_DONE_BIT] = s_q.done;
            end
            REF_ADDR: rdata[REF_W-1:0] = ref_cnt;
            LP_ADDR: rdata[LP_W-1:0] = lp_cnt;
            INT_STAT_ADDR: rdata[INT_W-1:0] = s_q.int_stat;
            INT_MASK_ADDR: rdata[INT_W-1:0] = s_q.int_mask;
            default: hit = 1'b0;
        endcase
    end

    assign wr_ctrl = access & apb_i.pwrite & (apb_i.paddr == CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        start = 1'b0;
        abort = 1'b0;
        limit = s_q.ctrl[CTRL_SRC_BIT] ? LIM_XTAL : LIM_INT;
        // zero-wait slave: data captured in setup, ready in the access cycle
        if (setup) begin
            s_d.pready = 1'b1;
            s_d.prdata = rdata;
            s_d.pslverr = ~hit;
        end
        // reading the low-power count retires the done flag
        if (access && !apb_i.pwrite && (apb_i.paddr == LP_ADDR)) begin
            s_d.done = 1'b0;
        end
        if (access && apb_i.pwrite) begin
            case (apb_i.paddr)
                TRIM_ADDR: s_d.trim = apb_i.pwdata[TRIM_W-1:0];
                CTRL_ADDR: begin
                    s_d.ctrl = apb_i.pwdata[CTRL_W-1:0];
                    start = apb_i.pwdata[CTRL_EN_BIT] & ~s_q.ctrl[CTRL_EN_BIT] & ~apb_i.pwdata[CTRL_RST_BIT];
                    abort = ~apb_i.pwdata[CTRL_EN_BIT] & s_q.busy;
                end
                INT_STAT_ADDR: s_d.int_stat = s_q.int_stat & ~apb_i.pwdata[INT_W-1:0];
                INT_MASK_ADDR: s_d.int_mask = apb_i.pwdata[INT_W-1:0];
                default: ;
            endcase
        end
        // hardware sets below come after the clears, so a set in the same cycle wins
        if (s_d.ctrl[CTRL_RST_BIT]) begin
            s_d.busy = 1'b0;
            s_d.timer = '0;
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.timer = '0;
        end else if (abort) begin
            s_d.busy = 1'b0;
        end else if (s_q.busy && ref_full) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.int_stat[INT_DONE_BIT] = 1'b1;
        end else if (s_q.busy && (s_q.timer >= limit)) begin
            // a dead reference would otherwise leave the pass running forever
            s_d.busy = 1'b0;
            s_d.int_stat[INT_TMO_BIT] = 1'b1;
        end else if (s_q.busy) begin
            s_d.timer = s_q.timer + 20'h00001;
        end
        s_d.irq = |(s_d.int_stat & s_d.int_mask);
    end

    // counters run only with the pass; start clears both so each pass begins at zero
    assign run = s_d.busy;
    assign ref_clr = start | s_d.ctrl[CTRL_RST_BIT] | s_d.ctrl[CTRL_CLR_REF_BIT];
    assign lp_clr = start | s_d.ctrl[CTRL_RST_BIT] | s_d.ctrl[CTRL_CLR_LP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{trim: TRIM_RST, ctrl: CTRL_RST, int_stat: INT_RST, int_mask: INT_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // the trim code goes straight to the oscillator; a larger code slows it
    assign lp_trim = s_q.trim;
    assign irq = s_q.irq;
    assign apb_o = '{prdata: s_q.prdata, pready: s_q.pready, pslverr: s_q.pslverr};

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_wr_trim;
        access && apb_i.pwrite && (apb_i.paddr == TRIM_ADDR);
    endsequence

    sequence seq_start;
        wr_ctrl && apb_i.pwdata[CTRL_EN_BIT] && !s_q.ctrl[CTRL_EN_BIT] && !apb_i.pwdata[CTRL_RST_BIT];
    endsequence

    sequence seq_abort;
        wr_ctrl && !apb_i.pwdata[CTRL_EN_BIT] && s_q.busy;
    endsequence

    sequence seq_read_lp;
        access && !apb_i.pwrite && (apb_i.paddr == LP_ADDR);
    endsequence

    stop_at_full_a: assert property (
        (s_q.busy && ref_full && !wr_ctrl) |=> (!s_q.busy && s_q.done && (ref_cnt == REF_FULL))
    ) else $error("pass did not stop at full reference count");

    counts_frozen_a: assert property (
        (!s_q.busy && !wr_ctrl && !s_q.ctrl[CTRL_RST_BIT]) |=> ($stable(ref_cnt) && $stable(lp_cnt))
    ) else $error("counters moved while no pass runs");

    trim_write_a: assert property (
        seq_wr_trim |=> (lp_trim == $past(apb_i.pwdata[3:0]))
    ) else $error("trim write not applied to low four bits");

    lp_step_a: assert property (
        ($changed(lp_cnt) && !$past(lp_clr)) |-> (lp_cnt == $past(lp_cnt) + 10'h001)
    ) else $error("low-power count jumped");

    cal_reset_a: assert property (
        s_q.ctrl[CTRL_RST_BIT] |-> (!s_q.busy && (ref_cnt == 9'h000) && (lp_cnt == 10'h000))
    ) else $error("calibration reset left counters or pass active");

    clear_counts_a: assert property (
        (s_q.ctrl[CTRL_CLR_REF_BIT] |-> (ref_cnt == 9'h000)) and (s_q.ctrl[CTRL_CLR_LP_BIT] |-> (lp_cnt == 10'h000))
    ) else $error("counter clear bit did not clear");

    start_pass_a: assert property (
        seq_start |=> (s_q.busy && (ref_cnt == 9'h000) && (lp_cnt == 10'h000))
    ) else $error("start did not begin a clean pass");

    abort_pass_a: assert property (
        seq_abort |=> (!s_q.busy ##1 !s_q.busy)
    ) else $error("abort did not end the pass");

    done_read_a: assert property (
        (seq_read_lp and !(s_q.busy && ref_full)) |=> !s_q.done
    ) else $error("reading low-power count did not clear done");

    busy_read_a: assert property (
        (setup && !apb_i.pwrite && (apb_i.paddr == STAT_ADDR)) |=> (apb_o.pready && (apb_o.prdata[0] == $past(s_q.busy)))
    ) else $error("status read does not show busy");

    pass_bound_a: assert property (
        s_q.busy |-> (s_q.timer <= limit)
    ) else $error("pass timer overran its limit");

endmodule

// ---- test/test_low_power_osc_calibration.sv ----
// self-checking bench for the oscillator calibration block
module test_low_power_osc_calibration
    import lpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk;
    logic presetn;
    lpc_apb_req_t req;
    lpc_apb_rsp_t rsp;
    logic prec_osc, xtal_osc, lp_osc;
    logic prec_on, xtal_on;
    logic [1:0] phase;
    logic [TRIM_W-1:0] lp_trim;
    logic irq;
    int mismatches;
    int tests_run;
    logic [31:0] rd;
    logic err;

    // short watchdogs so the stalled-reference case finishes quickly
    lpc_calib #(.INT_TMO_CYC(8000), .XTAL_TMO_CYC(8000)) DUT (
        .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
        .prec_osc(prec_osc), .xtal_osc(xtal_osc), .lp_osc(lp_osc),
        .lp_trim(lp_trim), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // oscillators toggle every third pclk, prec_osc and xtal_osc only while prec_on and xtal_on are high, so the nominal rates match
    always @(posedge pclk) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2) begin
            prec_osc <= prec_on ? ~prec_osc : prec_osc;
            xtal_osc <= xtal_on ? ~xtal_osc : xtal_osc;
            lp_osc <= ~lp_osc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        tests_run++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            mismatches++;
            $display("MISMATCH %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask

    // one apb transfer; the request stands until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (rsp.pready === 1'b1) break;
        end
        if (n == 16) begin
            mismatches++;
            $display("MISMATCH pready expected 1 seen timeout");
            final_report();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < 4000; n++) begin
            apb(1'b0, STAT_ADDR, 32'h0);
            if (rd[STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 4000) begin
            mismatches++;
            $display("MISMATCH busy expected 0 seen timeout");
            final_report();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, TRIM_ADDR, 32'h0); chk("trim reset", 32'h0000_0008, rd);
        apb(1'b0, CTRL_ADDR, 32'h0); chk("ctrl reset", 32'h0000_0000, rd);
        apb(1'b0, STAT_ADDR, 32'h0); chk("stat reset", 32'h0000_0000, rd);
        apb(1'b0, REF_ADDR, 32'h0); chk("ref reset", 32'h0000_0000, rd);
        apb(1'b0, LP_ADDR, 32'h0); chk("lp reset", 32'h0000_0000, rd);
        apb(1'b1, TRIM_ADDR, 32'h0000_00FF);
        apb(1'b0, TRIM_ADDR, 32'h0); chk("trim reserved", 32'h0000_000F, rd);
        apb(1'b1, TRIM_ADDR, 32'h0000_0005);
        // the write lands on the edge the task returns at; look once the register has settled
        @(negedge pclk);
        chk("lp_trim pin", 32'h5, {28'h0, lp_trim});
        apb(1'b1, CTRL_ADDR, 32'h0000_00E0);
        apb(1'b0, CTRL_ADDR, 32'h0); chk("ctrl reserved", 32'h0000_0000, rd);
        apb(1'b0, 32'hFFFF_0460, 32'h0); chk("unmapped err", 32'h1, {31'h0, err});
        $display("test registers done");
    endtask

    // a full pass: busy while running, frozen reference count, done cleared by lp read
    task automatic t_pass(input logic [7:0] ctrl, input logic m, input logic [31:0] lo, input logic [31:0] hi);
        apb(1'b1, INT_STAT_ADDR, 32'h3);
        apb(1'b1, INT_MASK_ADDR, {31'h0, m});
        apb(1'b1, CTRL_ADDR, {24'h0, ctrl});
        apb(1'b0, STAT_ADDR, 32'h0); chk("stat busy", 32'h1, rd);
        wait_idle();
        apb(1'b0, STAT_ADDR, 32'h0); chk("stat done", 32'h2, rd);
        apb(1'b0, REF_ADDR, 32'h0); chk("ref frozen", 32'h0000_01FF, rd);
        apb(1'b0, REF_ADDR, 32'h0); chk("ref again", 32'h0000_01FF, rd);
        apb(1'b0, LP_ADDR, 32'h0); chk_rng("lp count", lo, hi, rd);
        apb(1'b0, STAT_ADDR, 32'h0); chk("done cleared", 32'h0, rd);
        apb(1'b0, INT_STAT_ADDR, 32'h0); chk("int done", 32'h1, rd);
        chk("irq level", {31'h0, m}, {31'h0, irq});
        apb(1'b1, INT_STAT_ADDR, 32'h1);
        apb(1'b0, INT_STAT_ADDR, 32'h0); chk("int cleared", 32'h0, rd);
        chk("irq low", 32'h0, {31'h0, irq});
        apb(1'b1, CTRL_ADDR, 32'h0);
        $display("test pass ctrl %h done", ctrl);
    endtask

    task automatic t_clear();
        apb(1'b1, CTRL_ADDR, 32'h0000_0002);
        apb(1'b0, REF_ADDR, 32'h0); chk("ref cleared", 32'h0, rd);
        apb(1'b0, LP_ADDR, 32'h0); chk_rng("lp kept", 32'h7D, 32'h81, rd);
        apb(1'b1, CTRL_ADDR, 32'h0000_0004);
        apb(1'b0, LP_ADDR, 32'h0); chk("lp cleared", 32'h0, rd);
        apb(1'b1, CTRL_ADDR, 32'h0000_0009);
        apb(1'b0, STAT_ADDR, 32'h0); chk("reset no busy", 32'h0, rd);
        apb(1'b0, REF_ADDR, 32'h0); chk("reset ref", 32'h0, rd);
        apb(1'b1, CTRL_ADDR, 32'h0);
        $display("test clear done");
    endtask

    task automatic t_abort();
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        repeat (20) apb(1'b0, STAT_ADDR, 32'h0);
        apb(1'b1, CTRL_ADDR, 32'h0);
        apb(1'b0, STAT_ADDR, 32'h0); chk("abort stat", 32'h0, rd);
        apb(1'b0, INT_STAT_ADDR, 32'h0); chk("abort int", 32'h0, rd);
        $display("test abort done");
    endtask

    // stalled reference: the watchdog ends the pass without done
    task automatic t_stall();
        prec_on <= 1'b0;
        apb(1'b1, CTRL_ADDR, 32'h0000_0001);
        wait_idle();
        apb(1'b0, STAT_ADDR, 32'h0); chk("stall stat", 32'h0, rd);
        apb(1'b0, INT_STAT_ADDR, 32'h0); chk("stall int", 32'h2, rd);
        apb(1'b1, INT_STAT_ADDR, 32'h2);
        apb(1'b1, CTRL_ADDR, 32'h0);
        prec_on <= 1'b1;
        $display("test stall done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        req = '0;
        prec_osc = 1'b0;
        xtal_osc = 1'b0;
        lp_osc = 1'b0;
        prec_on = 1'b1;
        xtal_on = 1'b1;
        phase = 2'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pass(8'h01, 1'b1, 32'h1FD, 32'h201);
        t_pass(8'h11, 1'b0, 32'h7D, 32'h81);
        t_clear();
        t_abort();
        t_stall();
        final_report();
    end

endmodule
